// >>> hw/bpm_pkg.sv
// Package for the bridge power, clock and configuration manager.
// Assumes a single 100 MHz system clock domain.
package bpm_pkg;

  // System clock rate
  localparam int unsigned CLK_HZ          = 100_000_000;

  // Operating clock selections
  localparam logic [1:0]  CLKSEL_48M      = 2'h0;
  localparam logic [1:0]  CLKSEL_24M      = 2'h1;
  localparam logic [1:0]  CLKSEL_12M      = 2'h2;
  localparam logic [1:0]  CLKSEL_IDLE     = 2'h3;
  localparam logic [1:0]  CLKSEL_RST      = CLKSEL_48M;

  // Frequencies in kHz, as printed
  localparam int unsigned FREQ_48M_KHZ    = 48_000;
  localparam int unsigned FREQ_24M_KHZ    = 24_000;
  localparam int unsigned FREQ_12M_KHZ    = 12_000;
  localparam int unsigned FREQ_IDLE_KHZ   = 30;

  // Idle inactivity time in seconds, and its cycle count
  localparam int unsigned IDLE_TIME_S     = 5;
  localparam longint unsigned IDLE_CYC    = longint'(IDLE_TIME_S) * longint'(CLK_HZ);

  // Pin count and function codes
  localparam int unsigned NUM_PINS        = 14;
  localparam logic [3:0]  PFUNC_GPIO      = 4'h0;
  localparam logic [3:0]  PFUNC_WAKE      = 4'h1;
  localparam logic [3:0]  PFUNC_RING      = 4'h2;
  localparam logic [3:0]  PFUNC_RST       = PFUNC_GPIO;

  // Vendor parameter word: bit positions
  localparam int unsigned VP_IDLE_EN_BIT  = 0;
  localparam int unsigned VP_RING_EN_BIT  = 1;
  localparam int unsigned VP_WIDTH        = 2;
  localparam logic [1:0]  VP_RST          = 2'h0;

  // Pin index of the two wake sources
  localparam int unsigned WAKE_PIN_IDX    = 8;
  localparam int unsigned RING_PIN_IDX    = 11;

  // Resume signalling length in cycles
  localparam int unsigned RESUME_CYC      = 16;

  // Power-up loader states, Gray coded along the path
  typedef enum logic [1:0] {
    BPM_LD_PROBE = 2'b00,
    BPM_LD_WAIT  = 2'b01,
    BPM_LD_APPLY = 2'b11,
    BPM_LD_DONE  = 2'b10
  } bpm_ld_state_t;

endpackage

// >>> hw/bpm_sync.sv
// Two-flop synchroniser bank for pin inputs.
// Assumes the input is asynchronous to clk_sys.
`timescale 1ns/10ps
module bpm_sync #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input  wire logic         clk_sys,
  input  wire logic         rst_n,
  input  wire logic         clk_en,
  // Data
  input  wire logic [W-1:0] d_async,
  output logic      [W-1:0] q_sync
);

  logic [W-1:0] meta_r;

  // First stage is read only by the second
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '1;                                 // Pins idle high: no false edge
      q_sync <= '1;                                 // after reset on RX or wake pins
    end else if (clk_en) begin
      meta_r <= d_async;
      q_sync <= meta_r;
    end
  end

endmodule

// >>> hw/bpm_top.sv
// Power, clock and configuration manager of a USB HID serial bridge.
// Assumes a USB core giving suspend, remote-wakeup and command strobes,
// and an I2C engine that reports the EEPROM probe result.
`timescale 1ns/10ps
module bpm_top
  import bpm_pkg::*;
#(
  parameter int unsigned     NPIN      = NUM_PINS,
  parameter longint unsigned IDLE_CNT  = IDLE_CYC
) (
  // Clock, reset, enable
  input  wire logic            clk_sys,
  input  wire logic            rst_n,
  input  wire logic            clk_en,
  // USB core side
  input  wire logic            usb_clk_req,
  input  wire logic [1:0]      usb_clk_sel,
  input  wire logic            usb_suspend,
  input  wire logic            usb_rwu_allowed,
  input  wire logic            usb_pfunc_req,
  input  wire logic [3:0]      usb_pfunc_idx,
  input  wire logic [3:0]      usb_pfunc_val,
  input  wire logic            usb_gpio_req,
  input  wire logic [NPIN-1:0] usb_gpio_val,
  input  wire logic [NPIN-1:0] usb_gpio_oe,
  // Data activity
  input  wire logic            xfer_activity,
  // Parameter sources
  input  wire logic [VP_WIDTH-1:0] fuse_params,
  input  wire logic            eeprom_done,
  input  wire logic            eeprom_present,
  input  wire logic [VP_WIDTH-1:0] eeprom_params,
  // Pins
  input  wire logic            uart_rx_pin,
  input  wire logic [NPIN-1:0] dio_in,
  output logic [NPIN-1:0]      dio_out,
  output logic [NPIN-1:0]      dio_oe,
  // Status and control outputs
  output logic                 eeprom_probe,
  output logic                 cfg_done,
  output logic [1:0]           sys_clk_sel,
  output logic                 idle_active,
  output logic                 clk_gate_en,
  output logic                 usb_resume
);

  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  logic [NPIN:0] pins_s;
  bpm_sync #(.W(NPIN+1)) u_sync (
    .clk_sys (clk_sys),
    .rst_n   (rst_n),
    .clk_en  (clk_en),
    .d_async ({uart_rx_pin, dio_in}),
    .q_sync  (pins_s)
  );
  logic rx_s, rx_d_r, wake_d_r, ring_d_r;
  assign rx_s = pins_s[NPIN];

  // Edge history of the synchronised pins
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rx_d_r   <= 1'b1;
      wake_d_r <= 1'b1;
      ring_d_r <= 1'b1;
    end else if (clk_en) begin
      rx_d_r   <= rx_s;
      wake_d_r <= pins_s[WAKE_PIN_IDX];
      ring_d_r <= pins_s[RING_PIN_IDX];
    end
  end

  logic rx_act, wake_ev, ring_ev;
  assign rx_act  = rx_s != rx_d_r;
  // Wake inputs are active low; a falling edge is the event
  assign wake_ev = wake_d_r & ~pins_s[WAKE_PIN_IDX];
  assign ring_ev = ring_d_r & ~pins_s[RING_PIN_IDX];

  //////////////////////////////////////////////////////////////////////////////
  // Power-up parameter loader

  bpm_ld_state_t ld_r;
  logic [VP_WIDTH-1:0] vp_r;

  // Probe first, then choose the source; EEPROM wins when present
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ld_r         <= BPM_LD_PROBE;
      vp_r         <= VP_RST;
      eeprom_probe <= 1'b0;
      cfg_done     <= 1'b0;
    end else if (clk_en) begin
      case (ld_r)
        BPM_LD_PROBE: begin
          eeprom_probe <= 1'b1;
          ld_r         <= BPM_LD_WAIT;
        end
        BPM_LD_WAIT: begin
          eeprom_probe <= 1'b0;
          if (eeprom_done) begin
            ld_r <= BPM_LD_APPLY;
            vp_r <= eeprom_present ? eeprom_params : fuse_params;
          end
        end
        BPM_LD_APPLY: begin
          cfg_done <= 1'b1;
          ld_r     <= BPM_LD_DONE;
        end
        BPM_LD_DONE: ld_r <= BPM_LD_DONE;
        default:     ld_r <= BPM_LD_PROBE;
      endcase
    end
  end

  logic idle_en, ring_en;
  assign idle_en = vp_r[VP_IDLE_EN_BIT];
  assign ring_en = vp_r[VP_RING_EN_BIT];

  //////////////////////////////////////////////////////////////////////////////
  // Pin function table

  logic [3:0] pfunc_r [NPIN];
  logic       cfg_apply;
  assign cfg_apply = (ld_r == BPM_LD_APPLY);

  // One entry per pin; the configured default gives wake and ring duties
  for (genvar i = 0; i < NPIN; i++) begin : g_pin
    localparam logic [3:0] DEF = (i == WAKE_PIN_IDX) ? PFUNC_WAKE :
                                 (i == RING_PIN_IDX) ? PFUNC_RING : PFUNC_GPIO;
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        pfunc_r[i] <= PFUNC_RST;
      end else if (clk_en) begin
        if (cfg_apply) begin
          pfunc_r[i] <= DEF;
        end else if (cfg_done && usb_pfunc_req && usb_pfunc_idx == 4'(i)) begin
          pfunc_r[i] <= usb_pfunc_val;
        end
      end
    end

    // GPIO pins follow host commands; other functions are inputs here
    always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
        dio_out[i] <= 1'b0;
        dio_oe[i]  <= 1'b0;
      end else if (clk_en) begin
        if (pfunc_r[i] != PFUNC_GPIO) begin
          dio_oe[i] <= 1'b0;
        end else if (usb_gpio_req) begin
          dio_out[i] <= usb_gpio_val[i];
          dio_oe[i]  <= usb_gpio_oe[i];
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Operating clock selection and idle timer

  logic [1:0]  norm_sel_r;
  logic [39:0] quiet_r;
  logic        quiet_done;
  assign quiet_done = (quiet_r >= 40'(IDLE_CNT - 1));

  // Host request picks the normal frequency; idle code is not accepted
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      norm_sel_r <= CLKSEL_RST;
    end else if (clk_en && usb_clk_req && usb_clk_sel != CLKSEL_IDLE) begin
      norm_sel_r <= usb_clk_sel;
    end
  end

  // Quiet counter: any transfer or RX edge restarts it
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      quiet_r <= '0;
    end else if (clk_en) begin
      if (xfer_activity || rx_act || !idle_en || !cfg_done) begin
        quiet_r <= '0;
      end else if (!quiet_done) begin
        quiet_r <= quiet_r + 40'h1;
      end
    end
  end

  // Idle entry and exit; receive activity wins over entry
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      idle_active <= 1'b0;
    end else if (clk_en) begin
      if (rx_act || xfer_activity || !idle_en) begin
        idle_active <= 1'b0;
      end else if (quiet_done) begin
        idle_active <= 1'b1;
      end
    end
  end

  // Output clock select tracks idle one cycle later
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sys_clk_sel <= CLKSEL_RST;
    end else if (clk_en) begin
      sys_clk_sel <= idle_active ? CLKSEL_IDLE : norm_sel_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Suspend gating and remote wakeup

  logic       wake_src;
  logic [4:0] res_cnt_r;
  assign wake_src = (pfunc_r[WAKE_PIN_IDX] == PFUNC_WAKE && wake_ev) ||
                    (pfunc_r[RING_PIN_IDX] == PFUNC_RING && ring_en && ring_ev);

  // Clocks stay gated for the whole suspend
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      clk_gate_en <= 1'b1;
    end else if (clk_en) begin
      clk_gate_en <= ~usb_suspend;
    end
  end

  // Fixed-length resume pulse while suspended and permitted
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      res_cnt_r  <= '0;
      usb_resume <= 1'b0;
    end else if (clk_en) begin
      if (res_cnt_r != 5'h0) begin
        res_cnt_r  <= res_cnt_r - 5'h1;
        usb_resume <= (res_cnt_r != 5'h1);
      end else if (usb_suspend && usb_rwu_allowed && wake_src) begin
        res_cnt_r  <= 5'(RESUME_CYC);
        usb_resume <= 1'b1;
      end else begin
        usb_resume <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  a_gate_follows_susp: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en |=> clk_gate_en == !$past(usb_suspend))
    else $error("clock gate does not follow suspend");
  a_idle_needs_en: assert property (@(posedge clk_sys) disable iff (!rst_n)
    idle_active |-> idle_en)
    else $error("idle active while disabled");
  a_rx_exits_idle: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (clk_en && rx_act) |=> !idle_active)
    else $error("RX activity did not leave idle");
  a_xfer_clears_cnt: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (clk_en && xfer_activity) |=> quiet_r == 40'h0)
    else $error("transfer did not restart idle timer");
  a_idle_sel_slow: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (clk_en && idle_active) |=> sys_clk_sel == CLKSEL_IDLE)
    else $error("idle without slow clock");
  a_sel_legal: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !idle_active && $past(!idle_active) |-> sys_clk_sel != CLKSEL_IDLE)
    else $error("illegal normal clock");
  a_resume_needs_rwu: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(usb_resume) |-> $past(usb_suspend && usb_rwu_allowed))
    else $error("resume without permission");
  a_resume_len: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(usb_resume) && clk_en |-> usb_resume [*2])
    else $error("resume too short");
  a_eeprom_wins: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (ld_r == BPM_LD_WAIT && eeprom_done && eeprom_present && clk_en)
      |=> vp_r == $past(eeprom_params))
    else $error("EEPROM parameters not applied");
  a_probe_first: assert property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(cfg_done) |-> ##0 $past(ld_r) == BPM_LD_APPLY)
    else $error("config done without load");

  c_idle_entry:  cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(idle_active));
  c_resume:      cover property (@(posedge clk_sys) disable iff (!rst_n) $rose(usb_resume));
  c_clk_switch:  cover property (@(posedge clk_sys) disable iff (!rst_n)
    usb_clk_req && usb_clk_sel == CLKSEL_12M);
  c_eeprom_load: cover property (@(posedge clk_sys) disable iff (!rst_n)
    $rose(cfg_done) && eeprom_present);

endmodule

// >>> tb/bpm_eeprom_model.sv
// External configuration EEPROM answering the power-up probe.
// Assumes the bench sets presence and contents before reset release.
`timescale 1ns/10ps
module bpm_eeprom_model
  import bpm_pkg::*;
#(
  parameter int unsigned DLY = 6
) (
  // Clock and reset
  input  wire logic                clk_sys,
  input  wire logic                rst_n,
  // Stored contents
  input  wire logic                present,
  input  wire logic [VP_WIDTH-1:0] rom_val,
  // Probe handshake
  input  wire logic                eeprom_probe,
  output logic                     eeprom_done,
  output logic                     eeprom_present,
  output logic [VP_WIDTH-1:0]      eeprom_params
);
  int cnt_r;
  // Slow bus scan, then done held as a level until reset
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r       <= 0;
      eeprom_done <= 1'b0;
    end else if (eeprom_probe) begin
      cnt_r <= DLY;
    end else if (cnt_r == 1) begin
      cnt_r       <= 0;
      eeprom_done <= 1'b1;
    end else if (cnt_r > 1) begin
      cnt_r <= cnt_r - 1;
    end
  end
  // Lines float when absent or not yet read: show inverse data
  assign eeprom_present = present & eeprom_done;
  assign eeprom_params  = eeprom_present ? rom_val : ~rom_val;
endmodule

// >>> tb/test_bridge_power_clock_config_manager.sv
// Self-checking bench for the power, clock and configuration manager.
// Assumes wake pins idle high and the EEPROM model answers the probe.
`timescale 1ns/10ps
module test_bridge_power_clock_config_manager;
  import bpm_pkg::*;
  `define CMP(nm, e, s) begin checks_done++; if ((s) !== (e)) begin fails++; \
    $display("Error %s expected %h seen %h", nm, (e), (s)); end end
  logic                clk_sys = 1'b0;
  logic                rst_n, clk_en, usb_clk_req, usb_suspend, usb_rwu_allowed;
  logic                usb_pfunc_req, usb_gpio_req, xfer_activity, uart_rx_pin, present;
  logic [1:0]          usb_clk_sel, fuse_params, rom_val, eeprom_params, sys_clk_sel;
  logic [3:0]          usb_pfunc_idx, usb_pfunc_val;
  logic [NUM_PINS-1:0] usb_gpio_val, usb_gpio_oe, dio_in, dio_out, dio_oe;
  logic                eeprom_done, eeprom_present, eeprom_probe, cfg_done;
  logic                idle_active, clk_gate_en, usb_resume;
  int                  fails, checks_done, cyc, exp_sel, n;
  int                  sel_q[$];

  // Short idle count keeps the run brief
  bpm_top #(.IDLE_CNT(50)) i_bpm_top (.clk_sys, .rst_n, .clk_en, .usb_clk_req,
    .usb_clk_sel, .usb_suspend, .usb_rwu_allowed, .usb_pfunc_req, .usb_pfunc_idx,
    .usb_pfunc_val, .usb_gpio_req, .usb_gpio_val, .usb_gpio_oe, .xfer_activity,
    .fuse_params, .eeprom_done, .eeprom_present, .eeprom_params, .uart_rx_pin,
    .dio_in, .dio_out, .dio_oe, .eeprom_probe, .cfg_done, .sys_clk_sel,
    .idle_active, .clk_gate_en, .usb_resume);
  bpm_eeprom_model i_bpm_eeprom_model (.clk_sys, .rst_n, .present, .rom_val,
    .eeprom_probe, .eeprom_done, .eeprom_present, .eeprom_params);

  always #5 clk_sys = ~clk_sys;
  // Hang guard, far above the expected run length
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 4000) begin
      fails++;
      print_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge clk_sys);
  endtask
  // Reset, then follow the probe until parameters are in force
  task automatic do_reset(input logic [1:0] fz, input logic [1:0] rom);
    step(1);
    rst_n <= 1'b0;
    fuse_params <= fz;
    rom_val <= rom;
    step(8);
    rst_n <= 1'b1;
    step(1);
    #1;
    `CMP("eeprom_probe", 1'b1, eeprom_probe)
    step(1);
    #1;
    `CMP("eeprom_probe", 1'b0, eeprom_probe)
    n = 0;
    while (cfg_done !== 1'b1 && n < 30) begin
      step(1);
      #1;
      n++;
    end
    `CMP("cfg_done", 1'b1, cfg_done)
  endtask
  // Pin held low long enough to cover the whole resume pulse
  task automatic wake_chk(input int idx, input logic want);
    step(1);
    dio_in[idx] <= 1'b0;
    n = 0;
    repeat (30) begin
      step(1);
      #1;
      if (usb_resume === 1'b1) n++;
    end
    `CMP("resume cycles", want ? 16 : 0, n)
    step(1);
    dio_in[idx] <= 1'b1;
  endtask
  task automatic set_func(input logic [3:0] idx, input logic [3:0] fc);
    step(1);
    usb_pfunc_idx <= idx;
    usb_pfunc_val <= fc;
    usb_pfunc_req <= 1'b1;
    step(1);
    usb_pfunc_req <= 1'b0;
    step(1);
  endtask
  // Only pins in gmask carry the function GPIO
  task automatic gpio_chk(input logic [NUM_PINS-1:0] gmask);
    logic [NUM_PINS-1:0] v, e;
    v = NUM_PINS'($urandom);
    e = NUM_PINS'($urandom);
    step(1);
    usb_gpio_val <= v;
    usb_gpio_oe <= e;
    usb_gpio_req <= 1'b1;
    step(1);
    usb_gpio_req <= 1'b0;
    step(2);
    #1;
    `CMP("dio_oe", e & gmask, dio_oe)
    `CMP("dio_out", v & gmask, dio_out & gmask)
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'h5F13));
    {rst_n, usb_clk_req, usb_suspend, usb_rwu_allowed, usb_pfunc_req, usb_gpio_req} = '0;
    {usb_clk_sel, usb_pfunc_idx, usb_pfunc_val, usb_gpio_val, usb_gpio_oe} = '0;
    {clk_en, xfer_activity, uart_rx_pin, present} = '1;
    {fuse_params, rom_val} = '0;
    dio_in = '1;
    // EEPROM enables idle and ring wake, fuse enables nothing
    do_reset(2'h0, 2'h3);
    gpio_chk(14'h36FF);
    sel_q = '{3, 2, 1, 0};
    repeat (5) sel_q.push_back($urandom % 4);
    exp_sel = CLKSEL_RST;
    foreach (sel_q[i]) begin
      step(1);
      usb_clk_sel <= 2'(sel_q[i]);
      usb_clk_req <= 1'b1;
      step(1);
      usb_clk_req <= 1'b0;
      if (sel_q[i] != 3) exp_sel = sel_q[i];
      step(2);
      #1;
      `CMP("sys_clk_sel", 2'(exp_sel), sys_clk_sel)
    end
    // Clock enable low freezes the block: a request then is lost
    step(1);
    clk_en <= 1'b0;
    usb_clk_sel <= 2'((exp_sel + 1) % 3);
    usb_clk_req <= 1'b1;
    step(1);
    usb_clk_req <= 1'b0;
    step(2);
    #1;
    `CMP("sys_clk_sel frozen", 2'(exp_sel), sys_clk_sel)
    step(1);
    clk_en <= 1'b1;
    // Quiet period broken once, then left to run out
    step(1);
    xfer_activity <= 1'b0;
    step(30);
    xfer_activity <= 1'b1;
    step(1);
    xfer_activity <= 1'b0;
    step(40);
    #1;
    `CMP("idle_active", 1'b0, idle_active)
    step(15);
    #1;
    `CMP("idle_active", 1'b1, idle_active)
    `CMP("sys_clk_sel", CLKSEL_IDLE, sys_clk_sel)
    step(1);
    uart_rx_pin <= 1'b0;
    step(8);
    #1;
    `CMP("sys_clk_sel", 2'(exp_sel), sys_clk_sel)
    step(1);
    uart_rx_pin <= 1'b1;
    xfer_activity <= 1'b1;
    usb_suspend <= 1'b1;
    usb_rwu_allowed <= 1'b1;
    step(2);
    #1;
    `CMP("clk_gate_en", 1'b0, clk_gate_en)
    wake_chk(WAKE_PIN_IDX, 1'b1);
    wake_chk(RING_PIN_IDX, 1'b1);
    usb_rwu_allowed <= 1'b0;
    wake_chk(WAKE_PIN_IDX, 1'b0);
    usb_suspend <= 1'b0;
    step(2);
    #1;
    `CMP("clk_gate_en", 1'b1, clk_gate_en)
    // Fuse enables all, EEPROM nothing: EEPROM must win
    do_reset(2'h3, 2'h0);
    step(1);
    xfer_activity <= 1'b0;
    step(70);
    #1;
    `CMP("idle_active", 1'b0, idle_active)
    step(1);
    xfer_activity <= 1'b1;
    usb_suspend <= 1'b1;
    usb_rwu_allowed <= 1'b1;
    wake_chk(RING_PIN_IDX, 1'b0);
    usb_suspend <= 1'b0;
    set_func(4'h2, PFUNC_WAKE);
    set_func(4'h3, PFUNC_RING);
    set_func(4'h8, PFUNC_GPIO);
    gpio_chk(14'h37F3);
    // Pin 8 now plain GPIO: its edges must not wake the host
    usb_suspend <= 1'b1;
    wake_chk(WAKE_PIN_IDX, 1'b0);
    // No EEPROM on the bus: floating lines ignored, fuse enables apply
    present <= 1'b0;
    do_reset(2'h3, 2'h3);
    step(1);
    xfer_activity <= 1'b0;
    step(60);
    #1;
    `CMP("idle_active", 1'b1, idle_active)
    step(1);
    xfer_activity <= 1'b1;
    wake_chk(RING_PIN_IDX, 1'b1);
    print_verdict();
  end
endmodule
